/* File: verilog/sbw_regs.sv */
// system-control bank: brown-out, tick calibration, irq latency, nmi source, wake start
// assumes an AXI4-Lite master on aclk and peripheral interrupt levels on aclk
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module sbw_regs
  import sbw_pkg::*;
#(
  parameter int N_WAKE = SBW_WAKE_N,
  parameter int N_IRQ = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SBW_BOD_LEVELS-1:0] bod_rst_below,
  input wire logic [SBW_BOD_LEVELS-1:0] bod_irq_below,
  input wire logic [N_WAKE-1:0] wake_pins,
  input wire logic [N_IRQ-1:0] periph_irq,
  output logic [N_IRQ-1:0] nvic_irq,
  output logic nmi_out,
  output logic [N_WAKE-1:0] wake_irq,
  output logic bod_irq_out,
  output logic bod_reset_req,
  output logic [SBW_TICK_W-1:0] tick_timer_calib_word,
  output logic [SBW_LAT_W-1:0] irq_min_latency,
  output logic irq
);

  // ****************************************
  // software-visible state
  // ****************************************
  logic [1:0] brownout_reset_level_reg;
  logic [1:0] brownout_irq_level_reg;
  logic brownout_reset_enable_reg;
  logic [SBW_TICK_W-1:0] tick_calibration_reg;
  logic [SBW_LAT_W-1:0] irq_min_latency_reg;
  logic [SBW_NMI_NUM_W-1:0] nmi_source_number_reg;
  logic nmi_source_enable_reg;
  logic [N_WAKE-1:0] wake_edge_select_reg;
  logic [N_WAKE-1:0] wake_start_enable_reg;
  logic [N_WAKE-1:0] wake_start_clear_reg;
  logic [SBW_EV_N-1:0] int_status_reg;
  logic [SBW_EV_N-1:0] int_enable_reg;

  // ****************************************
  // bus channel state
  // ****************************************
  logic aw_have_reg;
  logic w_have_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // ****************************************
  // sub-blocks
  // ****************************************
  sbw_bod_if bod_bus ();
  sbw_wake_if #(.N(N_WAKE)) wake_bus ();

  assign bod_bus.reset_level = brownout_reset_level_reg;
  assign bod_bus.irq_level = brownout_irq_level_reg;
  assign bod_bus.reset_enable = brownout_reset_enable_reg;
  assign wake_bus.edge_sel = wake_edge_select_reg;
  assign wake_bus.enable = wake_start_enable_reg;
  assign wake_bus.clear = wake_start_clear_reg;

  sbw_bod_sel #(
    .LEVELS(SBW_BOD_LEVELS)
  ) u_bod (
    .aclk(aclk),
    .aresetn(aresetn),
    .rst_below(bod_rst_below),
    .irq_below(bod_irq_below),
    .bus(bod_bus.sel)
  );

  sbw_wake_start #(
    .N(N_WAKE)
  ) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(wake_pins),
    .bus(wake_bus.start)
  );

  // ****************************************
  // write address and data capture
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_have_reg <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // ****************************************
  // write decode
  // ****************************************
  always_comb
  begin
    if (aw_addr_reg == SBW_ADDR_BOD_CTRL)
    begin
      wr_hit = 1'b1;
    end
    else if (aw_addr_reg == SBW_ADDR_TICK_CAL || aw_addr_reg == SBW_ADDR_IRQ_LAT)
    begin
      wr_hit = 1'b1;
    end
    else if (aw_addr_reg == SBW_ADDR_NMI_SEL || aw_addr_reg == SBW_ADDR_WAKE_EDGE)
    begin
      wr_hit = 1'b1;
    end
    else if (aw_addr_reg == SBW_ADDR_WAKE_EN || aw_addr_reg == SBW_ADDR_WAKE_CLR)
    begin
      wr_hit = 1'b1;
    end
    else if (aw_addr_reg == SBW_ADDR_INT_CLR || aw_addr_reg == SBW_ADDR_INT_EN)
    begin
      wr_hit = 1'b1;
    end
    else
    begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SBW_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? SBW_RESP_OKAY : SBW_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {brownout_reset_enable_reg, brownout_irq_level_reg, brownout_reset_level_reg} <= SBW_RST_BOD;
      tick_calibration_reg <= SBW_RST_TICK;
      irq_min_latency_reg <= SBW_RST_LAT;
      nmi_source_number_reg <= '0;
      nmi_source_enable_reg <= 1'b0;
      wake_edge_select_reg <= '0;
      wake_start_enable_reg <= '0;
      int_enable_reg <= '0;
    end
    else if (do_write)
    begin
      if (aw_addr_reg == SBW_ADDR_BOD_CTRL)
      begin
        brownout_reset_level_reg <= w_strb_reg[0] ? w_data_reg[SBW_BOD_RST_LSB +: 2] : brownout_reset_level_reg;
        brownout_irq_level_reg <= w_strb_reg[0] ? w_data_reg[SBW_BOD_IRQ_LSB +: 2] : brownout_irq_level_reg;
        brownout_reset_enable_reg <= w_strb_reg[0] ? w_data_reg[SBW_BOD_RST_EN_BIT] : brownout_reset_enable_reg;
      end
      else if (aw_addr_reg == SBW_ADDR_TICK_CAL)
      begin
        tick_calibration_reg <= SBW_TICK_W'(sbw_merge(32'(tick_calibration_reg), w_data_reg, w_strb_reg));
      end
      else if (aw_addr_reg == SBW_ADDR_IRQ_LAT)
      begin
        irq_min_latency_reg <= w_strb_reg[0] ? w_data_reg[SBW_LAT_W-1:0] : irq_min_latency_reg;
      end
      else if (aw_addr_reg == SBW_ADDR_NMI_SEL)
      begin
        nmi_source_number_reg <= w_strb_reg[0] ? w_data_reg[SBW_NMI_NUM_W-1:0] : nmi_source_number_reg;
        nmi_source_enable_reg <= w_strb_reg[3] ? w_data_reg[SBW_NMI_EN_BIT] : nmi_source_enable_reg;
      end
      else if (aw_addr_reg == SBW_ADDR_WAKE_EDGE)
      begin
        wake_edge_select_reg <= N_WAKE'(sbw_merge(32'(wake_edge_select_reg), w_data_reg, w_strb_reg));
      end
      else if (aw_addr_reg == SBW_ADDR_WAKE_EN)
      begin
        wake_start_enable_reg <= N_WAKE'(sbw_merge(32'(wake_start_enable_reg), w_data_reg, w_strb_reg));
      end
      else if (aw_addr_reg == SBW_ADDR_INT_EN)
      begin
        int_enable_reg <= SBW_EV_N'(sbw_merge(32'(int_enable_reg), w_data_reg, w_strb_reg));
      end
    end
  end

  // one-cycle clear strobe towards the start cells
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wake_start_clear_reg <= '0;
    end
    else if (do_write && aw_addr_reg == SBW_ADDR_WAKE_CLR)
    begin
      wake_start_clear_reg <= N_WAKE'(sbw_merge(32'h00000000, w_data_reg, w_strb_reg));
    end
    else
    begin
      wake_start_clear_reg <= '0;
    end
  end

  // ****************************************
  // sticky event status, set wins over clear
  // ****************************************
  logic bod_irq_d_reg;
  logic bod_rst_d_reg;
  logic [SBW_EV_N-1:0] ev_set;
  logic [SBW_EV_N-1:0] ev_clr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bod_irq_d_reg <= 1'b0;
      bod_rst_d_reg <= 1'b0;
    end
    else
    begin
      bod_irq_d_reg <= bod_bus.bod_irq;
      bod_rst_d_reg <= bod_bus.bod_reset;
    end
  end

  always_comb
  begin
    ev_set = '0;
    ev_set[SBW_EV_BOD_IRQ] = bod_bus.bod_irq && !bod_irq_d_reg;
    ev_set[SBW_EV_BOD_RST] = bod_bus.bod_reset && !bod_rst_d_reg;
    ev_set[SBW_EV_WAKE] = |wake_bus.set_pulse;
  end

  assign ev_clr = (do_write && aw_addr_reg == SBW_ADDR_INT_CLR) ?
                  SBW_EV_N'(sbw_merge(32'h00000000, w_data_reg, w_strb_reg)) : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_status_reg <= '0;
    end
    else
    begin
      int_status_reg <= (int_status_reg & ~ev_clr) | ev_set;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == SBW_ADDR_BOD_CTRL)
    begin
      rd_word[4:0] = {brownout_reset_enable_reg, brownout_irq_level_reg, brownout_reset_level_reg};
    end
    else if (s_axi_araddr == SBW_ADDR_TICK_CAL)
    begin
      rd_word[SBW_TICK_W-1:0] = tick_calibration_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_IRQ_LAT)
    begin
      rd_word[SBW_LAT_W-1:0] = irq_min_latency_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_NMI_SEL)
    begin
      rd_word[SBW_NMI_NUM_W-1:0] = nmi_source_number_reg;
      rd_word[SBW_NMI_EN_BIT] = nmi_source_enable_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_WAKE_EDGE)
    begin
      rd_word[N_WAKE-1:0] = wake_edge_select_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_WAKE_EN)
    begin
      rd_word[N_WAKE-1:0] = wake_start_enable_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_WAKE_PEND)
    begin
      rd_word[N_WAKE-1:0] = wake_bus.pending & wake_start_enable_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_INT_STAT)
    begin
      rd_word[SBW_EV_N-1:0] = int_status_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_INT_EN)
    begin
      rd_word[SBW_EV_N-1:0] = int_enable_reg;
    end
    else if (s_axi_araddr == SBW_ADDR_WAKE_CLR || s_axi_araddr == SBW_ADDR_INT_CLR)
    begin
      rd_word = 32'h00000000;
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= SBW_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? SBW_RESP_OKAY : SBW_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // outputs towards controller, timer and reset logic
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nvic_irq <= '0;
      nmi_out <= 1'b0;
      irq <= 1'b0;
      tick_timer_calib_word <= SBW_RST_TICK;
      irq_min_latency <= SBW_RST_LAT;
    end
    else
    begin
      nvic_irq <= periph_irq;
      nmi_out <= nmi_source_enable_reg && periph_irq[nmi_source_number_reg];
      irq <= |((int_status_reg | ev_set) & ~(ev_clr & ~ev_set) & int_enable_reg);
      tick_timer_calib_word <= tick_calibration_reg;
      irq_min_latency <= irq_min_latency_reg;
    end
  end

  assign wake_irq = wake_bus.pending;
  assign bod_irq_out = bod_bus.bod_irq;
  assign bod_reset_req = bod_bus.bod_reset;

endmodule : sbw_regs

`default_nettype wire

/* File: verilog/sbw_pkg.sv */
// package: offsets, field layouts and reset values of the system-control bank
// assumes a 32-bit AXI4-Lite slave at byte addresses
package sbw_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [31:0] SBW_ADDR_BOD_CTRL = 32'h40048150;
  localparam logic [31:0] SBW_ADDR_TICK_CAL = 32'h40048154;
  localparam logic [31:0] SBW_ADDR_IRQ_LAT = 32'h40048170;
  localparam logic [31:0] SBW_ADDR_NMI_SEL = 32'h40048174;
  localparam logic [31:0] SBW_ADDR_WAKE_EDGE = 32'h40048200;
  localparam logic [31:0] SBW_ADDR_WAKE_EN = 32'h40048204;
  localparam logic [31:0] SBW_ADDR_WAKE_CLR = 32'h40048208;
  localparam logic [31:0] SBW_ADDR_WAKE_PEND = 32'h4004820c;
  localparam logic [31:0] SBW_ADDR_INT_STAT = 32'h40048300;
  localparam logic [31:0] SBW_ADDR_INT_CLR = 32'h40048304;
  localparam logic [31:0] SBW_ADDR_INT_EN = 32'h40048308;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int SBW_BOD_RST_LSB = 0;
  localparam int SBW_BOD_IRQ_LSB = 2;
  localparam int SBW_BOD_RST_EN_BIT = 4;
  localparam int SBW_TICK_W = 26;
  localparam int SBW_LAT_W = 8;
  localparam int SBW_NMI_NUM_W = 5;
  localparam int SBW_NMI_EN_BIT = 31;
  localparam int SBW_WAKE_N = 13;
  localparam int SBW_BOD_LEVELS = 4;
  localparam int SBW_EV_N = 3;
  localparam int SBW_EV_BOD_IRQ = 0;
  localparam int SBW_EV_BOD_RST = 1;
  localparam int SBW_EV_WAKE = 2;

  // ****************************************
  // reset values and bus answers
  // ****************************************
  localparam logic [4:0] SBW_RST_BOD = 5'h00;
  localparam logic [SBW_TICK_W-1:0] SBW_RST_TICK = 26'h0000004;
  localparam logic [SBW_LAT_W-1:0] SBW_RST_LAT = 8'h10;
  localparam logic [1:0] SBW_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBW_RESP_SLVERR = 2'h2;
  localparam logic [1:0] SBW_BOD_IRQ_RSVD = 2'h0;

  // byte-strobe merge of a write into an old word
  function automatic logic [31:0] sbw_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction : sbw_merge

endpackage : sbw_pkg

/* File: verilog/sbw_links.sv */
// interfaces between the register bank and its brown-out and wake blocks
// assumes all signals are in the aclk domain
`timescale 1ns/1ps
`default_nettype none

interface sbw_bod_if;
  logic [1:0] reset_level;
  logic [1:0] irq_level;
  logic reset_enable;
  logic bod_irq;
  logic bod_reset;
  modport ctl (output reset_level, output irq_level, output reset_enable, input bod_irq, input bod_reset);
  modport sel (input reset_level, input irq_level, input reset_enable, output bod_irq, output bod_reset);
endinterface : sbw_bod_if

interface sbw_wake_if #(parameter int N = 13);
  logic [N-1:0] edge_sel;
  logic [N-1:0] enable;
  logic [N-1:0] clear;
  logic [N-1:0] pending;
  logic [N-1:0] set_pulse;
  modport ctl (output edge_sel, output enable, output clear, input pending, input set_pulse);
  modport start (input edge_sel, input enable, input clear, output pending, output set_pulse);
endinterface : sbw_wake_if

`default_nettype wire

/* File: verilog/sbw_bod_sel.sv */
// brown-out threshold selector: synchronises comparator levels and picks one
// assumes comparator inputs are high while the supply is below that threshold
`timescale 1ns/1ps
`default_nettype none

module sbw_bod_sel
  import sbw_pkg::*;
#(
  parameter int LEVELS = SBW_BOD_LEVELS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [LEVELS-1:0] rst_below,
  input wire logic [LEVELS-1:0] irq_below,
  sbw_bod_if.sel bus
);

  // ****************************************
  // two-stage synchronisers
  // ****************************************
  logic [LEVELS-1:0] rst_s1_reg;
  logic [LEVELS-1:0] rst_s2_reg;
  logic [LEVELS-1:0] irq_s1_reg;
  logic [LEVELS-1:0] irq_s2_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_s1_reg <= '0;
      rst_s2_reg <= '0;
      irq_s1_reg <= '0;
      irq_s2_reg <= '0;
    end
    else
    begin
      rst_s1_reg <= rst_below;
      rst_s2_reg <= rst_s1_reg;
      irq_s1_reg <= irq_below;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // ****************************************
  // level selection
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus.bod_irq <= 1'b0;
      bus.bod_reset <= 1'b0;
    end
    else
    begin
      bus.bod_irq <= (bus.irq_level != SBW_BOD_IRQ_RSVD) && irq_s2_reg[bus.irq_level];
      bus.bod_reset <= bus.reset_enable && rst_s2_reg[bus.reset_level];
    end
  end

endmodule : sbw_bod_sel

`default_nettype wire

/* File: verilog/sbw_wake_start.sv */
// wake start logic: per-pin edge detect, enable gating and pending latch
// assumes pin inputs are synchronous to aclk
`timescale 1ns/1ps
`default_nettype none

module sbw_wake_start
  import sbw_pkg::*;
#(
  parameter int N = SBW_WAKE_N
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] pins,
  sbw_wake_if.start bus
);

  logic primed_reg;
  logic [N-1:0] prev_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primed_reg <= 1'b0;
      prev_reg <= '0;
    end
    else
    begin
      primed_reg <= 1'b1;
      prev_reg <= pins;
    end
  end

  // ****************************************
  // one start cell per wake input
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_cell
      logic hit;
      assign hit = primed_reg && bus.enable[g] &&
                   (bus.edge_sel[g] ? (pins[g] && !prev_reg[g]) : (!pins[g] && prev_reg[g]));
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          bus.pending[g] <= 1'b0;
          bus.set_pulse[g] <= 1'b0;
        end
        else
        begin
          bus.set_pulse[g] <= hit && !bus.pending[g];
          if (hit)
          begin
            bus.pending[g] <= 1'b1;
          end
          else if (bus.clear[g])
          begin
            bus.pending[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule : sbw_wake_start

`default_nettype wire

/* File: verif/sbw_nvic_model.sv */
// interrupt controller model: counts nmi entries, sees enabled wake lines
// assumes all inputs are on aclk
`timescale 1ns/1ps
`default_nettype none
module sbw_nvic_model
(
  input wire logic aclk,
  input wire logic nmi_out,
  input wire logic [12:0] wake_irq,
  input wire logic [12:0] wake_en,
  output logic [7:0] nmi_cnt,
  output logic wake_seen
);
  logic nmi_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  always @(posedge aclk)
  begin
    nmi_q <= nmi_out;
    if (nmi_out && !nmi_q) cnt_q <= cnt_q + 8'h01;
  end
  assign nmi_cnt = cnt_q;
  assign wake_seen = |(wake_irq & wake_en);
endmodule : sbw_nvic_model
`default_nettype wire

/* File: verif/sbw_regs_checker.sv */
// port assertions for the system-control bank
// assumes binding into sbw_regs
`timescale 1ns/1ps
`default_nettype none
module sbw_regs_checker
  import sbw_pkg::*;
#(
  parameter int N_WAKE = SBW_WAKE_N,
  parameter int N_IRQ = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SBW_BOD_LEVELS-1:0] bod_rst_below,
  input wire logic [SBW_BOD_LEVELS-1:0] bod_irq_below,
  input wire logic [N_WAKE-1:0] wake_pins,
  input wire logic [N_IRQ-1:0] periph_irq,
  input wire logic [N_IRQ-1:0] nvic_irq,
  input wire logic nmi_out,
  input wire logic [N_WAKE-1:0] wake_irq,
  input wire logic bod_irq_out,
  input wire logic bod_reset_req,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // checks
  // ****
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_nmi_cause: assert property (nmi_out |-> $past(periph_irq) != '0)
    else $error("nmi without request");
  a_nvic_copy: assert property ($past(aresetn) |-> nvic_irq == $past(periph_irq))
    else $error("normal request lost");
  a_wake_cause: assert property ((wake_irq & ~$past(wake_irq)) != '0 |->
    $past(wake_pins) != $past(wake_pins, 2)) else $error("wake without edge");
  a_bod_reset: assert property ($rose(bod_reset_req) |-> $past(|bod_rst_below, 3))
    else $error("reset without comparator");
  a_bod_irq: assert property (bod_irq_out |-> $past(|bod_irq_below, 3))
    else $error("brown-out irq without comparator");
  c_nmi: cover property ($rose(nmi_out));
  c_wake: cover property ($rose(|wake_irq));
  c_irq: cover property ($rose(irq));
endmodule : sbw_regs_checker
bind sbw_regs sbw_regs_checker #(.N_WAKE(N_WAKE), .N_IRQ(N_IRQ)) u_chk (.*);
`default_nettype wire

/* File: verif/sbw_regs_tb.sv */
// self-checking bench for the system-control bank
// assumes the package, checker and interrupt controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module sbw_regs_tb
  import sbw_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nmi_out, bod_irq_out, bod_reset_req, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, periph_irq, nvic_irq, v;
  logic [3:0] s_axi_wstrb, bod_rst_below, bod_irq_below;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] wake_pins, wake_irq;
  logic [25:0] tick_timer_calib_word;
  logic [7:0] irq_min_latency, nmi_cnt;
  logic wake_seen;
  logic [33:0] exp_q[$];
  int n_fail, n_tests, n;
  sbw_regs DUT (.*);
  sbw_nvic_model u_nvic (.aclk(aclk), .nmi_out(nmi_out), .wake_irq(wake_irq), .wake_en(13'h0003),
    .nmi_cnt(nmi_cnt), .wake_seen(wake_seen));
  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad;
    logic wd;
    exp_q.push_back({r, 32'h0});
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (s_axi_awready && !ad) s_axi_awvalid <= 0;
      if (s_axi_wready && !wd) s_axi_wvalid <= 0;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
    end
    repeat (1 + $urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    repeat (1 + $urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask : rd
  task automatic hold(input int c);
    repeat (c) @(posedge aclk);
  endtask : hold
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  initial
  begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  initial
  begin
    #60000;
    n_fail++;
    finish_test();
  end
  // ****
  // scenarios
  // ****
  initial
  begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, bod_rst_below, bod_irq_below, periph_irq} = '0;
    wake_pins = 13'h1ffe;
    aresetn = 0;
    v = $urandom(32'h4d2eb49b);
    hold(6);
    aresetn <= 1;
    hold(1);
    rd(SBW_ADDR_BOD_CTRL, 32'h0, SBW_RESP_OKAY);
    rd(SBW_ADDR_TICK_CAL, 32'h4, SBW_RESP_OKAY);
    rd(SBW_ADDR_IRQ_LAT, 32'h10, SBW_RESP_OKAY);
    rd(SBW_ADDR_NMI_SEL, 32'h0, SBW_RESP_OKAY);
    rd(SBW_ADDR_WAKE_EDGE, 32'h0, SBW_RESP_OKAY);
    v = $urandom & 32'h03ffffff;
    wr(SBW_ADDR_TICK_CAL, v | 32'hfc000000, SBW_RESP_OKAY);
    rd(SBW_ADDR_TICK_CAL, v, SBW_RESP_OKAY);
    chk("tick", tick_timer_calib_word, v[25:0]);
    v = $urandom_range(255);
    wr(SBW_ADDR_IRQ_LAT, v, SBW_RESP_OKAY);
    rd(SBW_ADDR_IRQ_LAT, v, SBW_RESP_OKAY);
    chk("lat", irq_min_latency, v[7:0]);
    wr(32'h40048400, v, SBW_RESP_SLVERR);
    rd(32'h40048400, 32'h0, SBW_RESP_SLVERR);
    repeat (3)
    begin
      n = $urandom_range(31);
      wr(SBW_ADDR_NMI_SEL, 32'h80000000 | n, SBW_RESP_OKAY);
      periph_irq <= 32'h1 << n;
      hold(2);
      chk("nmi", nmi_out, 1'b1);
      chk("nvic", nvic_irq, 32'h1 << n);
      periph_irq <= ~(32'h1 << n);
      hold(2);
      chk("nmi", nmi_out, 1'b0);
      wr(SBW_ADDR_NMI_SEL, n, SBW_RESP_OKAY);
      periph_irq <= 32'h1 << n;
      hold(2);
      chk("nmi", nmi_out, 1'b0);
      periph_irq <= 0;
    end
    chk("nmi_cnt", nmi_cnt, 8'h3);
    wr(SBW_ADDR_BOD_CTRL, 32'h0b, SBW_RESP_OKAY);
    bod_irq_below <= 4'hb;
    bod_rst_below <= 4'h8;
    hold(4);
    chk("bod_irq", bod_irq_out, 1'b0);
    chk("bod_rst", bod_reset_req, 1'b0);
    bod_irq_below <= 4'h4;
    wr(SBW_ADDR_BOD_CTRL, 32'h1b, SBW_RESP_OKAY);
    hold(4);
    chk("bod_irq", bod_irq_out, 1'b1);
    chk("bod_rst", bod_reset_req, 1'b1);
    chk("irq", irq, 1'b0);
    rd(SBW_ADDR_INT_STAT, 32'h3, SBW_RESP_OKAY);
    wr(SBW_ADDR_INT_EN, 32'h3, SBW_RESP_OKAY);
    hold(2);
    chk("irq", irq, 1'b1);
    {bod_irq_below, bod_rst_below} <= '0;
    wr(SBW_ADDR_INT_CLR, 32'h3, SBW_RESP_OKAY);
    hold(2);
    chk("irq", irq, 1'b0);
    wr(SBW_ADDR_WAKE_EDGE, 32'h1, SBW_RESP_OKAY);
    wr(SBW_ADDR_WAKE_EN, 32'h1003, SBW_RESP_OKAY);
    wr(SBW_ADDR_INT_EN, 32'h4, SBW_RESP_OKAY);
    wake_pins <= 13'h0001;
    hold(3);
    chk("wake", wake_irq, 13'h1003);
    chk("irq", irq, 1'b1);
    chk("seen", wake_seen, 1'b1);
    rd(SBW_ADDR_WAKE_PEND, 32'h1003, SBW_RESP_OKAY);
    wr(SBW_ADDR_WAKE_CLR, 32'h1, SBW_RESP_OKAY);
    wake_pins <= 13'h0000;
    hold(3);
    chk("wake", wake_irq, 13'h1002);
    rd(SBW_ADDR_WAKE_PEND, 32'h1002, SBW_RESP_OKAY);
    finish_test();
  end
endmodule : sbw_regs_tb
`default_nettype wire
